// File: sadc_regs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// Register offsets (byte addresses on the plain register port)
`define SADC_RESULT_OFS     8'h0A
`define SADC_CTRL_OFS       8'h0B

// Control/status field positions
`define SADC_DONE_BIT       7
`define SADC_ON_BIT         5
`define SADC_SEL_MSB        3
`define SADC_SEL_LSB        0

// Reset values
`define SADC_CTRL_RST       8'h00
`define SADC_RESULT_RST     8'h00

// Timing: converter clock is the system clock divided by four
`define SADC_CLK_DIV        4
`define SADC_CONV_PERIODS   12
`define SADC_STEP_PERIODS   8
`define SADC_LOAD_PERIODS   (`SADC_CONV_PERIODS - `SADC_STEP_PERIODS)

`endif

// File: sadc_pkg.sv
// Types shared by the converter control modules
package sadc_pkg;

   // Conversion sequencer states, one-hot
   typedef enum logic [2:0] {
      SADC_IDLE = 3'b001,
      SADC_LOAD = 3'b010,
      SADC_STEP = 3'b100
   } sadc_state_e;

   typedef logic [7:0] sadc_byte_t;
   typedef logic [3:0] sadc_sel_t;

endpackage

// File: sadc_sar_if.sv
// Interface between the sequencer and the approximation register
`timescale 1ns/1ps
`default_nettype none

interface sadc_sar_if;
   logic       start;     // Clear the trial word and begin at the top bit
   logic       step;      // Resolve one bit with the comparator answer
   logic       cmp;       // Comparator answer, synchronised
   logic [7:0] trial;     // Trial code to the comparison network
   logic [7:0] code;      // Resolved code
   logic       last;      // The bit being resolved is bit 0

   modport seq (output start, output step, output cmp, input trial, input code, input last);
   modport sar (input start, input step, input cmp, output trial, output code, output last);
endinterface

`default_nettype wire

// File: sadc_sar.sv
// Successive-approximation register: one bit resolved per step
`timescale 1ns/1ps
`default_nettype none

module sadc_sar (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic nrst_in,
   // Sequencer side
   sadc_sar_if.sar   sar
);
   import sadc_pkg::*;

   sadc_byte_t trial_q;
   sadc_byte_t mask_q;

   // Trial bit walks from bit 7 down; kept on comparator answer
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trial_q <= 8'h00;
         mask_q  <= 8'h00;
      end else if (sar.start) begin
         trial_q <= 8'h80;
         mask_q  <= 8'h80;
      end else if (sar.step && mask_q != 8'h00) begin
         // Input at or above trial keeps the bit, saturating at FFh with no overflow
         trial_q <= (sar.cmp ? trial_q : (trial_q & ~mask_q)) | (mask_q >> 1);
         mask_q  <= mask_q >> 1;
      end
   end

   assign sar.trial = trial_q;
   assign sar.code  = sar.cmp ? trial_q : (trial_q & ~mask_q);
   assign sar.last  = mask_q[0];

endmodule // sadc_sar

`default_nettype wire

// File: sadc_ctrl.sv
// 8-bit successive-approximation converter control with register port
//
// Summary of operation
// [R1] Sampled input becomes 8-bit code by approximation
// [R2] Sixteen inputs chosen by input select field
// [R3] Result register holds code; one control register
// [R4] Input at high reference gives FFh, no overflow
// [R5] Input at low reference gives 00h
// [R6] While on, load and convert phases alternate
// [R7] Eight steps with sample capacitor disconnected
// [R8] Twelve converter clocks, converter clock is sysclk/4
// [R9] Setting converter on starts continuous conversions
// [R10] Done flag set at every conversion end
// [R11] No interrupt; software polls done flag
// [R12] Result held until next conversion finishes
// [R13] Control write with converter on restarts conversion
// [R14] Clearing converter on stops conversions
// [R15] Wait mode does not affect the converter
// [R16] Analog use leaves pin readable as logic
// [R17] Result read or control write clears done
// [R18] Done flag is control bit 7
// [R19] Input select is control bits 3 to 0
// [R20] Four spare periods load selected channel
//
// Our own choices: the strobed register port and the register addresses.
`include "sadc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sadc_ctrl (
   // Clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             nrst_in,
   // Register port
   input  wire logic [7:0]       reg_addr_in,
   input  wire logic [7:0]       reg_wdata_in,
   input  wire logic             reg_wr_in,
   input  wire logic             reg_rd_in,
   output logic      [7:0]       reg_rdata_out,
   // Analog front end
   input  wire logic             cmp_in,
   output logic      [7:0]       trial_out,
   output sadc_pkg::sadc_sel_t   mux_sel_out,
   output logic                  mux_connect_out,
   output logic                  sample_hold_out,
   output logic                  analog_enable_out
);
   import sadc_pkg::*;

   localparam int DIV_W = $clog2(`SADC_CLK_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(`SADC_CLK_DIV - 1);
   localparam logic [3:0] LOAD_LAST = 4'(`SADC_LOAD_PERIODS - 1);

   sadc_sar_if sar_if ();

   sadc_state_e      state_q;
   logic [DIV_W-1:0] div_q;
   logic [3:0]       cnt_q;
   logic             on_q;
   sadc_sel_t        sel_q;
   logic             done_q;
   sadc_byte_t       result_q;
   logic             cmp_meta_q;
   logic             cmp_sync_q;
   logic             tick;
   logic             ctrl_wr;
   logic             result_rd;
   logic             restart;
   logic             finish;
   logic             load_end;

   sadc_sar u_sar (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .sar        (sar_if.sar)
   );

   // Decoded register accesses
   assign ctrl_wr   = reg_wr_in && reg_addr_in == `SADC_CTRL_OFS;
   assign result_rd = reg_rd_in && reg_addr_in == `SADC_RESULT_OFS;
   // Any control write with the on bit set aborts and restarts
   assign restart   = ctrl_wr && reg_wdata_in[`SADC_ON_BIT];            // [R13]

   // Comparator is asynchronous to us: two flops before use
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmp_meta_q <= 1'b0;
         cmp_sync_q <= 1'b0;
      end else begin
         cmp_meta_q <= cmp_in;
         cmp_sync_q <= cmp_meta_q;
      end
   end

   // Converter clock enable: one system clock in four
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_q <= '0;
      end else if (restart || !on_q) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + DIV_W'(1);                                     // [R8]
      end
   end
   assign tick = div_q == DIV_LAST;

   assign load_end = state_q == SADC_LOAD && tick && cnt_q == LOAD_LAST;
   // Gated by the on bit: a switch-off write must not let a final step finish late
   assign finish   = state_q == SADC_STEP && tick && sar_if.last && on_q;  // [R14]

   // Sequencer: load four periods, then eight steps, repeat while on
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= SADC_IDLE;
         cnt_q   <= 4'h0;
      end else if (restart) begin
         state_q <= SADC_LOAD;                                           // [R9] [R13]
         cnt_q   <= 4'h0;
      end else if (!on_q) begin
         state_q <= SADC_IDLE;                                           // [R14]
         cnt_q   <= 4'h0;
      end else begin
         unique case (state_q)
            SADC_IDLE: begin
               state_q <= SADC_LOAD;
               cnt_q   <= 4'h0;
            end
            SADC_LOAD: begin
               if (load_end) begin
                  state_q <= SADC_STEP;                                  // [R20]
                  cnt_q   <= 4'h0;
               end else if (tick) begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            SADC_STEP: begin
               if (finish) begin
                  state_q <= SADC_LOAD;                                  // [R6]
                  cnt_q   <= 4'h0;
               end else if (tick) begin
                  cnt_q <= cnt_q + 4'h1;                                 // [R7]
               end
            end
            default: begin
               state_q <= SADC_IDLE;
               cnt_q   <= 4'h0;
            end
         endcase
      end
   end

   // Approximation register control
   assign sar_if.start = load_end;
   assign sar_if.step  = state_q == SADC_STEP && tick;                   // [R1]
   assign sar_if.cmp   = cmp_sync_q;

   // Control bits; there is no wait-mode input, so wait cannot touch it
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         on_q  <= 1'b0;
         sel_q <= 4'h0;
      end else if (ctrl_wr) begin
         on_q  <= reg_wdata_in[`SADC_ON_BIT];                            // [R14] [R15]
         sel_q <= reg_wdata_in[`SADC_SEL_MSB:`SADC_SEL_LSB];             // [R2] [R19]
      end
   end

   // Result only replaced at a finished conversion; code saturates by search
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         result_q <= `SADC_RESULT_RST;
      end else if (finish && !restart) begin
         result_q <= sar_if.code;                                        // [R3] [R4] [R5] [R12]
      end
   end

   // Done flag: set wins over a result-read clear; control write aborts first
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         done_q <= 1'b0;
      end else if (ctrl_wr) begin
         done_q <= 1'b0;                                                 // [R13] [R17]
      end else if (finish) begin
         done_q <= 1'b1;                                                 // [R10] [R11]
      end else if (result_rd) begin
         done_q <= 1'b0;                                                 // [R17]
      end
   end

   // Read data one cycle after the strobe; unmapped reads give 00h
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in && reg_addr_in == `SADC_CTRL_OFS) begin
         reg_rdata_out <= {done_q, 1'b0, on_q, 1'b0, sel_q};             // [R18] [R19]
      end else if (result_rd) begin
         reg_rdata_out <= result_q;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   // Front-end controls registered; mux connected only while loading.
   // Digital port reads are elsewhere and never gated here.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trial_out         <= 8'h00;
         mux_sel_out       <= 4'h0;
         mux_connect_out   <= 1'b0;
         sample_hold_out   <= 1'b0;
         analog_enable_out <= 1'b0;
      end else begin
         trial_out         <= sar_if.trial;
         mux_sel_out       <= sel_q;                                     // [R2]
         mux_connect_out   <= state_q == SADC_LOAD;                      // [R20] [R16]
         sample_hold_out   <= state_q == SADC_STEP;                      // [R7]
         analog_enable_out <= on_q;                                      // [R14]
      end
   end

endmodule // sadc_ctrl

`default_nettype wire

// File: sadc_ctrl_monitor.sv
// Port checker for the converter control
`include "sadc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sadc_ctrl_monitor (
   // Clock, reset and register port
   input wire logic                sys_clk_in,
   input wire logic                nrst_in,
   input wire logic [7:0]          reg_addr_in,
   input wire logic [7:0]          reg_wdata_in,
   input wire logic                reg_wr_in,
   input wire logic                reg_rd_in,
   input wire logic [7:0]          reg_rdata_out,
   // Analog front end
   input wire logic                cmp_in,
   input wire logic [7:0]          trial_out,
   input wire sadc_pkg::sadc_sel_t mux_sel_out,
   input wire logic                mux_connect_out,
   input wire logic                sample_hold_out,
   input wire logic                analog_enable_out
);
   import sadc_pkg::*;
   logic [5:0] load_q;
   logic [5:0] step_q;
   logic       cw;
   logic       cw_q;

   // A control write restarts the load run; the front-end outputs lag by one
   // cycle, so the count restarts one cycle after the write
   assign cw = reg_wr_in && reg_addr_in == `SADC_CTRL_OFS;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cw_q   <= 1'b0;
         load_q <= 6'h00;
         step_q <= 6'h00;
      end else begin
         cw_q   <= cw;
         load_q <= (mux_connect_out && !cw_q) ? load_q + 6'h01 : 6'h00;
         step_q <= sample_hold_out ? step_q + 6'h01 : 6'h00;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);

   property p_rdata_idle; !$past(reg_rd_in) |-> reg_rdata_out == 8'h00; endproperty
   property p_ctrl_back;
      cw ##1 reg_rd_in && reg_addr_in == `SADC_CTRL_OFS
         |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h2F);
   endproperty
   // Control bit lands one edge after the write, the registered output one edge later
   property p_on; cw |-> ##2 analog_enable_out == $past(reg_wdata_in[5], 2); endproperty
   property p_sel;
      cw && reg_wdata_in[5] |-> ##2 mux_sel_out == $past(reg_wdata_in[3:0], 2);
   endproperty
   property p_load_len; mux_connect_out |-> load_q < 6'h10; endproperty
   property p_step_len; sample_hold_out |-> step_q < 6'h20; endproperty
   property p_load_step;
      $fell(mux_connect_out) && analog_enable_out && !$past(reg_wr_in) |-> sample_hold_out;
   endproperty
   property p_off;
      !$past(analog_enable_out) && !analog_enable_out |-> !mux_connect_out && !sample_hold_out;
   endproperty

   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
   a_on: assert property (p_on) else $error("enable not following write");
   a_sel: assert property (p_sel) else $error("select not following write");
   a_load_len: assert property (p_load_len) else $error("load phase too long");
   a_step_len: assert property (p_step_len) else $error("step phase too long");
   a_load_step: assert property (p_load_step) else $error("no step after load");
   a_off: assert property (p_off) else $error("front end active while off");

   c_step: cover property ($rose(sample_hold_out));
   c_done: cover property ($rose(reg_rdata_out[7]));
   c_off: cover property ($fell(analog_enable_out));
endmodule // sadc_ctrl_monitor

bind sadc_ctrl sadc_ctrl_monitor u_mon (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cmp_in(cmp_in), .trial_out(trial_out),
   .mux_sel_out(mux_sel_out), .mux_connect_out(mux_connect_out),
   .sample_hold_out(sample_hold_out), .analog_enable_out(analog_enable_out));

`default_nettype wire

// File: sadc_afe_model.sv
// Analog front end model: input mux, sample capacitor and comparator
`timescale 1ns/1ps
`default_nettype none

module sadc_afe_model (
   // Sixteen input levels, channel n in bits 8n+7 to 8n
   input  wire logic [127:0] level_in,
   // Control from the converter
   input  wire logic [7:0]   trial_in,
   input  wire logic [3:0]   sel_in,
   input  wire logic         connect_in,
   // Comparator answer
   output logic              cmp_out
);
   logic [7:0] held = 8'h00;

   // Capacitor follows the chosen input only while connected, then keeps its charge
   always @* if (connect_in) held = level_in[sel_in * 8 +: 8];
   // High when the held level reaches the trial code, so full scale saturates at FFh
   assign cmp_out = held >= trial_in;
endmodule // sadc_afe_model

`default_nettype wire

// File: sadc_ctrl_bench.sv
// Self-checking bench for the converter control
`include "sadc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sadc_ctrl_bench;
   import sadc_pkg::*;
   logic         sys_clk_in = 1'b0;
   logic         nrst_in = 1'b0;
   logic [7:0]   addr = 8'h00;
   logic [7:0]   wdata = 8'h00;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   logic [127:0] level = '0;
   logic [7:0]   rdata;
   logic [7:0]   trial;
   logic         cmp;
   logic         conn;
   logic         hold;
   logic         en;
   sadc_sel_t    sel;
   sadc_byte_t   v;
   int           miscompares = 0;
   int           checked = 0;
   int           n;

   // Free-running system clock
   always #5 sys_clk_in = ~sys_clk_in;

   sadc_ctrl uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .cmp_in(cmp), .trial_out(trial), .mux_sel_out(sel), .mux_connect_out(conn),
      .sample_hold_out(hold), .analog_enable_out(en));
   sadc_afe_model afe (.level_in(level), .trial_in(trial), .sel_in(sel),
      .connect_in(conn), .cmp_out(cmp));

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string name, input sadc_byte_t exp, input sadc_byte_t got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Each access starts just after an edge, so calls may follow with no gap
   task automatic wr_reg(input sadc_byte_t a, input sadc_byte_t d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_in);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input sadc_byte_t a, output sadc_byte_t d);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Poll the done flag; the bound cuts a stuck converter short
   task automatic wait_done(output int cnt);
      sadc_byte_t s;
      cnt = 0;
      s = 8'h00;
      while (s[7] !== 1'b1 && cnt < 100) begin
         rd_reg(`SADC_CTRL_OFS, s);
         cnt++;
      end
      if (cnt >= 100) begin
         miscompares++;
         conclude();
      end
   endtask

   initial begin
      repeat (4) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_reg(`SADC_CTRL_OFS, v);
      chk("ctrl reset", 8'h00, v);
      rd_reg(`SADC_RESULT_OFS, v);
      chk("result reset", 8'h00, v);
      rd_reg(8'h0C, v);
      chk("unmapped", 8'h00, v);
      // Channel n holds n*17, so channel 0 sits at low and 15 at high reference
      for (int ch = 0; ch < 16; ch++) begin
         level[ch * 8 +: 8] = 8'(ch * 17);
      end
      for (int ch = 0; ch < 16; ch++) begin
         wr_reg(`SADC_CTRL_OFS, 8'h20 | 8'(ch));
         wait_done(n);
         chk("conversion time", 8'h01, 8'(n >= 46 && n <= 52));
         rd_reg(`SADC_RESULT_OFS, v);
         chk("result", 8'(ch * 17), v);
         rd_reg(`SADC_CTRL_OFS, v);
         chk("done after read", 8'h20 | 8'(ch), v);
      end
      // Next conversion is loading already; the old result must stay
      level[127:120] = 8'h3C;
      rd_reg(`SADC_RESULT_OFS, v);
      chk("result held", 8'hFF, v);
      wait_done(n);
      rd_reg(`SADC_RESULT_OFS, v);
      chk("next result", 8'h3C, v);
      // Abort in mid-approximation and restart
      wr_reg(`SADC_CTRL_OFS, 8'h25);
      repeat (30) @(posedge sys_clk_in);
      wr_reg(`SADC_CTRL_OFS, 8'h25);
      wait_done(n);
      chk("restart time", 8'h01, 8'(n >= 46 && n <= 52));
      rd_reg(`SADC_RESULT_OFS, v);
      chk("restart result", 8'h55, v);
      // Switch off with reserved and done bits set, then an unmapped write
      wr_reg(`SADC_CTRL_OFS, 8'hD5);
      wr_reg(8'h0C, 8'hFF);
      repeat (100) @(posedge sys_clk_in);
      rd_reg(`SADC_CTRL_OFS, v);
      chk("ctrl off", 8'h05, v);
      chk("enable off", 8'h00, {7'h00, en});
      conclude();
   end
endmodule // sadc_ctrl_bench

`default_nettype wire
